// file: rtl/mio_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Code 01 loads target on a start edge when valid
// - Start bit after target begins positioning
// - Incremental adds current position to data
// - Code 03 acceleration stored when valid
// - Code 04 deceleration stored when valid
// - Continuous direction from direction bit
// - Start bit begins continuous operation
// - Code 12 origin return on start
// - Code 1E clears alarms on start
// - Code 1F positions to end setting
// - Switch honoured only if action bit15
// - Else positioning command switches from continuous
// - Response always eight bytes, fixed header
// - Byte 0 status bit layout
// - Byte 1 block number, byte 2 flags
// - Byte 3 axis and code, data LSB first
// - Trajectory bit set until operation done
// - Block bit clears on finish or fault
// - On-target when within completed width
// - Alarm clears only via clear command
// - Codes and data update only when valid
// - Rising start edge triggers, fall ignored
// - Start ignored while servo off
// - Valid message checked, error flagged
module mio_decoder #(
  parameter int DW = 32 // Command data width
) (
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire logic [7:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic o_pready, // APB ready
  output logic [31:0] o_prdata, // APB read data
  output logic o_pslverr, // APB error, unmapped address or write to a read-only register
  output logic o_traj_busy, // Trajectory in progress
  output logic o_start_pulse, // Motion start event
  output logic [1:0] o_op, // Motion operation kind
  output logic o_direction, // Continuous direction
  output logic o_hard_stop, // Hard stop level
  output logic o_smooth_stop, // Smooth stop level
  output logic o_servo_on // Servo enable
);
  // ****************************************
  // State
  // ****************************************
  // Operation kind as held in the state, declared before the struct uses it
  typedef logic [1:0] mio_op_sel_t;
  typedef struct packed {
    logic [63:0] stage;
    logic [63:0] rsp;
    logic [7:0] b0_prev;
    logic [4:0] cmd_code;
    logic [4:0] rsp_code;
    logic [DW-1:0] cmd_data;
    logic [DW-1:0] target;
    logic [DW-1:0] speed;
    logic [DW-1:0] accel;
    logic [DW-1:0] decel;
    logic [DW-1:0] cont_speed;
    logic [7:0] origin_type;
    logic [DW-1:0] end_pos;
    logic [31:0] act_def;
    logic [DW-1:0] inpos_w;
    logic [DW-1:0] cur_pos;
    logic [15:0] mon;
    logic [7:0] exec_blk;
    logic [7:0] blk_num;
    logic [DW-1:0] alarm_code;
    logic alarm;
    logic traj;
    logic blk_run;
    logic blk_fault;
    logic cmd_err;
    logic valid_echo;
    logic start_echo;
    logic servo;
    logic hstop;
    logic sstop;
    logic dir;
    logic start;
    mio_op_sel_t op;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } mio_state_s;

  mio_state_s s_q;
  mio_state_s s_d;

  // Signed window check, reused for on-target status
  function automatic logic mio_within(input logic [DW-1:0] pos, input logic [DW-1:0] tgt,
                                      input logic [DW-1:0] w);
    logic [DW-1:0] diff;
    diff = pos - tgt;
    if (diff[DW-1])
    begin
      diff = DW'(0) - diff;
    end
    return diff <= w;
  endfunction

  // Positive data check, used by rate and speed codes
  function automatic logic mio_positive(input logic [DW-1:0] v);
    return !v[DW-1] && (v != '0);
  endfunction

  logic access;
  logic on_target;
  assign access = i_psel && i_penable;
  assign on_target = mio_within(s_q.cur_pos, s_q.target, s_q.inpos_w);

  // ****************************************
  // Message decode and bus access
  // ****************************************
  // All fields of one committed message are applied here together
  always_comb
  begin
    logic [7:0] b0;
    logic [DW-1:0] data;
    logic [4:0] code;
    logic rise;
    logic bad;
    logic [7:0] st0;
    logic [7:0] st2;
    b0 = s_q.stage[7:0];
    data = s_q.stage[63:32];
    code = s_q.stage[20:16];
    rise = 1'b0;
    bad = 1'b0;
    st0 = 8'h00;
    st2 = 8'h00;
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.ready = 1'b0;
    s_d.slverr = 1'b0;
    // Motion engine completion events from the monitor register
    if (s_q.mon[mio_pkg::MON_DONE])
    begin
      s_d.traj = 1'b0;
      s_d.mon[mio_pkg::MON_DONE] = 1'b0;
    end
    if (s_q.mon[mio_pkg::MON_BLK_DONE] || s_q.mon[mio_pkg::MON_BLK_FAULT])
    begin
      s_d.blk_run = 1'b0;
      s_d.exec_blk = 8'h00;
      s_d.blk_fault = s_q.mon[mio_pkg::MON_BLK_FAULT];
      s_d.mon[mio_pkg::MON_BLK_DONE] = 1'b0;
      s_d.mon[mio_pkg::MON_BLK_FAULT] = 1'b0;
    end
    // Commit of the staged message, one cycle per message
    if (access && i_pwrite && i_paddr == mio_pkg::A_CTRL && i_pwdata[mio_pkg::CTRL_COMMIT])
    begin
      s_d.servo = b0[mio_pkg::B0_ENABLE];
      s_d.hstop = b0[mio_pkg::B0_HARD_STOP];
      s_d.sstop = b0[mio_pkg::B0_SMOOTH_STOP];
      s_d.dir = b0[mio_pkg::B0_DIRECTION];
      s_d.b0_prev = b0;
      if (b0[mio_pkg::B0_VALID])
      begin
        // Latch only valid data, checked for axis and sign
        s_d.cmd_code = code;
        s_d.rsp_code = s_q.stage[28:24];
        s_d.cmd_data = data;
        s_d.blk_num = s_q.stage[15:8];
        bad = (s_q.stage[23:21] != mio_pkg::AXIS_ID);
        if (code == mio_pkg::CMD_TARGET_SPD || code == mio_pkg::CMD_ACCEL ||
            code == mio_pkg::CMD_DECEL || code == mio_pkg::CMD_CONT_SPD)
        begin
          bad = bad || !mio_positive(data);
        end
        if (!bad && code == mio_pkg::CMD_TARGET_SPD)
        begin
          s_d.speed = data;
        end
        if (!bad && code == mio_pkg::CMD_ACCEL)
        begin
          s_d.accel = data;
        end
        if (!bad && code == mio_pkg::CMD_DECEL)
        begin
          s_d.decel = data;
        end
        if (!bad && code == mio_pkg::CMD_CONT_SPD)
        begin
          s_d.cont_speed = data;
        end
        if (!bad && code == mio_pkg::CMD_ORIGIN)
        begin
          s_d.origin_type = data[7:0];
        end
        s_d.cmd_err = bad || (s_q.cmd_err && !s_q.act_def[mio_pkg::ACT_ERRCLR_BIT]);
        s_d.valid_echo = 1'b1;
      end
      else
      begin
        s_d.valid_echo = 1'b0;
        s_d.cmd_err = 1'b0;
      end
      s_d.start_echo = b0[mio_pkg::B0_START_TRAJ];
      // Only a rising edge starts; a falling edge is not a stop
      rise = b0[mio_pkg::B0_START_TRAJ] && !s_q.b0_prev[mio_pkg::B0_START_TRAJ];
      if (rise && b0[mio_pkg::B0_ENABLE] && b0[mio_pkg::B0_VALID] && !bad)
      begin
        unique case (code)
          mio_pkg::CMD_TARGET_POS:
          begin
            // Absolute or incremental target, also valid mid continuous run
            s_d.target = b0[mio_pkg::B0_INCREMENTAL] ? s_q.cur_pos + data : data;
            if (!(s_q.traj && s_q.op == 2'(mio_pkg::MIO_OP_CONT) && s_q.act_def[mio_pkg::ACT_SWITCH_BIT]))
            begin
              s_d.op = 2'(mio_pkg::MIO_OP_POS);
              s_d.traj = 1'b1;
              s_d.start = 1'b1;
            end
          end
          mio_pkg::CMD_CONT_SPD:
          begin
            s_d.op = 2'(mio_pkg::MIO_OP_CONT);
            s_d.traj = 1'b1;
            s_d.start = 1'b1;
          end
          mio_pkg::CMD_ORIGIN:
          begin
            s_d.op = 2'(mio_pkg::MIO_OP_ORIGIN);
            s_d.traj = 1'b1;
            s_d.start = 1'b1;
          end
          mio_pkg::CMD_ALM_CLR:
          begin
            if (data[0])
            begin
              s_d.alarm = 1'b0;
              s_d.alarm_code = '0;
            end
          end
          mio_pkg::CMD_SWITCH_POS:
          begin
            if (s_q.act_def[mio_pkg::ACT_SWITCH_BIT] && s_q.traj && s_q.op == 2'(mio_pkg::MIO_OP_CONT))
            begin
              s_d.target = s_q.end_pos;
              s_d.op = 2'(mio_pkg::MIO_OP_POS);
              s_d.start = 1'b1;
            end
          end
          default:
          begin
            s_d.start = 1'b0;
          end
        endcase
      end
      if (b0[mio_pkg::B0_START_BLOCK] && !s_q.b0_prev[mio_pkg::B0_START_BLOCK] && b0[mio_pkg::B0_ENABLE])
      begin
        s_d.blk_run = 1'b1;
        s_d.blk_fault = 1'b0;
        s_d.exec_blk = b0[mio_pkg::B0_VALID] ? s_q.stage[15:8] : s_q.blk_num;
      end
      else if (!b0[mio_pkg::B0_START_BLOCK])
      begin
        s_d.blk_run = 1'b0;
      end
    end
    // Response assembly, refreshed every cycle
    st0 = {s_d.servo, s_d.valid_echo, s_q.mon[mio_pkg::MON_HOME], s_q.mon[mio_pkg::MON_EXT_STOP],
           s_d.alarm, on_target, s_d.blk_run, s_d.traj};
    st2 = {s_d.cmd_err, s_d.blk_fault, s_d.start_echo, s_q.mon[mio_pkg::MON_NSL],
           s_q.mon[mio_pkg::MON_PSL], s_q.mon[mio_pkg::MON_CCW], s_q.mon[mio_pkg::MON_CW],
           s_q.mon[mio_pkg::MON_READY]};
    unique case (s_d.rsp_code)
      mio_pkg::RSP_CUR_POS: data = s_q.cur_pos;
      mio_pkg::RSP_REF_POS: data = s_d.target;
      mio_pkg::RSP_CUR_SPD: data = s_q.speed;
      mio_pkg::RSP_ALM_CODE: data = s_d.alarm_code;
      default: data = '0;
    endcase
    s_d.rsp = {data, mio_pkg::AXIS_ID, s_d.rsp_code, st2, s_d.exec_blk, st0};
    // APB slave, zero wait states
    if (i_psel && !i_penable)
    begin
      s_d.ready = 1'b1;
    end
    if (access && i_pwrite)
    begin
      unique case (i_paddr)
        mio_pkg::A_CMD_LO: s_d.stage[31:0] = i_pwdata;
        mio_pkg::A_CMD_HI: s_d.stage[63:32] = i_pwdata;
        mio_pkg::A_CTRL:
        begin
          if (i_pwdata[mio_pkg::CTRL_ALM_SET])
          begin
            s_d.alarm = 1'b1;
          end
        end
        mio_pkg::A_ENDPOS: s_d.end_pos = i_pwdata;
        mio_pkg::A_ACTDEF: s_d.act_def = i_pwdata;
        mio_pkg::A_INPOS_W: s_d.inpos_w = i_pwdata;
        mio_pkg::A_CURPOS: s_d.cur_pos = i_pwdata;
        mio_pkg::A_MONITOR: s_d.mon = i_pwdata[15:0];
        mio_pkg::A_ALARM: s_d.alarm_code = i_pwdata;
        // Refused writes are flagged with ready in setup; a late flag would stand alone
        default: s_d.slverr = 1'b0;
      endcase
    end
    if (i_psel && !i_penable && !i_pwrite)
    begin
      unique case (i_paddr)
        mio_pkg::A_CMD_LO: s_d.rdata = s_q.stage[31:0];
        mio_pkg::A_CMD_HI: s_d.rdata = s_q.stage[63:32];
        mio_pkg::A_RSP_LO: s_d.rdata = s_q.rsp[31:0];
        mio_pkg::A_RSP_HI: s_d.rdata = s_q.rsp[63:32];
        mio_pkg::A_TARGET: s_d.rdata = s_q.target;
        mio_pkg::A_SPEED: s_d.rdata = s_q.speed;
        mio_pkg::A_ACCEL: s_d.rdata = s_q.accel;
        mio_pkg::A_DECEL: s_d.rdata = s_q.decel;
        mio_pkg::A_CONT: s_d.rdata = s_q.cont_speed;
        mio_pkg::A_ENDPOS: s_d.rdata = s_q.end_pos;
        mio_pkg::A_ACTDEF: s_d.rdata = s_q.act_def;
        mio_pkg::A_INPOS_W: s_d.rdata = s_q.inpos_w;
        mio_pkg::A_CURPOS: s_d.rdata = s_q.cur_pos;
        mio_pkg::A_MONITOR: s_d.rdata = {16'h0000, s_q.mon};
        mio_pkg::A_EXEC: s_d.rdata = {16'h0000, s_q.origin_type, s_q.exec_blk};
        mio_pkg::A_ALARM: s_d.rdata = s_q.alarm_code;
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    else if (i_psel && !i_penable)
    begin
      s_d.rdata = 32'h00000000;
    end
    if (i_psel && !i_penable)
    begin
      s_d.slverr = 1'b0;
    end
    if (i_psel && !i_penable && !i_pwrite)
    begin
      s_d.slverr = !(i_paddr inside {mio_pkg::A_CMD_LO, mio_pkg::A_CMD_HI, mio_pkg::A_CTRL,
        mio_pkg::A_RSP_LO, mio_pkg::A_RSP_HI, mio_pkg::A_TARGET, mio_pkg::A_SPEED,
        mio_pkg::A_ACCEL, mio_pkg::A_DECEL, mio_pkg::A_CONT, mio_pkg::A_ENDPOS,
        mio_pkg::A_ACTDEF, mio_pkg::A_INPOS_W, mio_pkg::A_CURPOS, mio_pkg::A_MONITOR,
        mio_pkg::A_EXEC, mio_pkg::A_ALARM});
    end
    if (i_psel && !i_penable && i_pwrite)
    begin
      s_d.slverr = !(i_paddr inside {mio_pkg::A_CMD_LO, mio_pkg::A_CMD_HI, mio_pkg::A_CTRL,
        mio_pkg::A_ENDPOS, mio_pkg::A_ACTDEF, mio_pkg::A_INPOS_W, mio_pkg::A_CURPOS,
        mio_pkg::A_MONITOR, mio_pkg::A_ALARM});
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign o_pready = s_q.ready;
  assign o_prdata = s_q.rdata;
  assign o_pslverr = s_q.slverr;
  assign o_traj_busy = s_q.traj;
  assign o_start_pulse = s_q.start;
  assign o_op = s_q.op;
  assign o_direction = s_q.dir;
  assign o_hard_stop = s_q.hstop;
  assign o_smooth_stop = s_q.sstop;
  assign o_servo_on = s_q.servo;
endmodule
`default_nettype wire

// file: rtl/mio_pkg.sv
package mio_pkg;
  // ****************************************
  // Command and response codes
  // ****************************************
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TARGET_POS = 5'h01;
  localparam logic [4:0] CMD_TARGET_SPD = 5'h02;
  localparam logic [4:0] CMD_ACCEL = 5'h03;
  localparam logic [4:0] CMD_DECEL = 5'h04;
  localparam logic [4:0] CMD_CONT_SPD = 5'h11;
  localparam logic [4:0] CMD_ORIGIN = 5'h12;
  localparam logic [4:0] CMD_ALM_CLR = 5'h1E;
  localparam logic [4:0] CMD_SWITCH_POS = 5'h1F;
  localparam logic [4:0] RSP_CUR_POS = 5'h01;
  localparam logic [4:0] RSP_REF_POS = 5'h02;
  localparam logic [4:0] RSP_CUR_SPD = 5'h03;
  localparam logic [4:0] RSP_TORQUE = 5'h05;
  localparam logic [4:0] RSP_ALM_CODE = 5'h1E;
  localparam logic [2:0] AXIS_ID = 3'h1;
  // ****************************************
  // Command byte 0 and action definition bit positions
  // ****************************************
  localparam int B0_ENABLE = 7;
  localparam int B0_VALID = 6;
  localparam int B0_HARD_STOP = 5;
  localparam int B0_SMOOTH_STOP = 4;
  localparam int B0_DIRECTION = 3;
  localparam int B0_INCREMENTAL = 2;
  localparam int B0_START_BLOCK = 1;
  localparam int B0_START_TRAJ = 0;
  localparam int ACT_SWITCH_BIT = 15;
  localparam int ACT_ERRCLR_BIT = 12;
  // ****************************************
  // APB register offsets
  // ****************************************
  localparam logic [7:0] A_CMD_LO = 8'h00;
  localparam logic [7:0] A_CMD_HI = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_RSP_LO = 8'h0C;
  localparam logic [7:0] A_RSP_HI = 8'h10;
  localparam logic [7:0] A_TARGET = 8'h14;
  localparam logic [7:0] A_SPEED = 8'h18;
  localparam logic [7:0] A_ACCEL = 8'h1C;
  localparam logic [7:0] A_DECEL = 8'h20;
  localparam logic [7:0] A_CONT = 8'h24;
  localparam logic [7:0] A_ENDPOS = 8'h28;
  localparam logic [7:0] A_ACTDEF = 8'h2C;
  localparam logic [7:0] A_INPOS_W = 8'h30;
  localparam logic [7:0] A_CURPOS = 8'h34;
  localparam logic [7:0] A_MONITOR = 8'h38;
  localparam logic [7:0] A_EXEC = 8'h3C;
  localparam logic [7:0] A_ALARM = 8'h40;
  // Control register: bit 0 commits staged message, bit 1 raises alarm
  localparam int CTRL_COMMIT = 0;
  localparam int CTRL_ALM_SET = 1;
  // Monitor inputs register bit positions
  localparam int MON_DONE = 0;
  localparam int MON_BLK_DONE = 1;
  localparam int MON_BLK_FAULT = 2;
  localparam int MON_HOME = 3;
  localparam int MON_EXT_STOP = 4;
  localparam int MON_READY = 5;
  localparam int MON_CW = 6;
  localparam int MON_CCW = 7;
  localparam int MON_PSL = 8;
  localparam int MON_NSL = 9;
  typedef enum logic [1:0] {MIO_OP_POS, MIO_OP_CONT, MIO_OP_ORIGIN} mio_op_e;
endpackage

// file: test/mio_decoder_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checker for the message decoder
// ****************************************
module mio_decoder_asserts (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_psel, // Select
  input wire logic i_penable, // Enable
  input wire logic i_pwrite, // Direction
  input wire logic [7:0] i_paddr, // Address
  input wire logic [31:0] i_pwdata, // Write data
  input wire logic o_pready, // Ready
  input wire logic [31:0] o_prdata, // Read data
  input wire logic o_pslverr, // Error
  input wire logic o_traj_busy, // Busy
  input wire logic o_start_pulse, // Start event
  input wire logic [1:0] o_op, // Operation
  input wire logic o_direction, // Direction
  input wire logic o_hard_stop, // Hard stop
  input wire logic o_smooth_stop, // Smooth stop
  input wire logic o_servo_on // Servo
);
  logic commit_w;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Accepted commit write; status may follow one or two cycles later
  assign commit_w = o_pready && i_pwrite && i_paddr == mio_pkg::A_CTRL && i_pwdata[mio_pkg::CTRL_COMMIT];
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence answer_s;
    i_penable && o_pready ##1 !o_pready;
  endsequence
  pready_timing_a: assert property (setup_s |=> answer_s) else $error("ready not in first access cycle");
  pready_qual_a: assert property (o_pready |-> i_psel && i_penable) else $error("ready outside transfer");
  slverr_qual_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  start_servo_a: assert property (o_start_pulse |-> o_servo_on) else $error("start with servo off");
  start_single_a: assert property (o_start_pulse |=> !o_start_pulse) else $error("start longer than one");
  start_cause_a: assert property (o_start_pulse |-> $past(commit_w) || $past(commit_w, 2))
    else $error("start without commit");
  start_busy_a: assert property (o_start_pulse |-> ##[0:1] o_traj_busy) else $error("start without busy");
  busy_rise_a: assert property ($rose(o_traj_busy) |-> o_start_pulse || $past(o_start_pulse))
    else $error("busy rose alone");
  op_change_a: assert property ($changed(o_op) |-> o_start_pulse || $past(o_start_pulse))
    else $error("operation changed alone");
  level_commit_a: assert property ($changed({o_servo_on, o_hard_stop, o_smooth_stop}) |->
    $past(commit_w) || $past(commit_w, 2)) else $error("level changed without commit");
endmodule
bind mio_decoder mio_decoder_asserts i_mio_decoder_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_traj_busy(o_traj_busy), .o_start_pulse(o_start_pulse),
  .o_op(o_op), .o_direction(o_direction), .o_hard_stop(o_hard_stop), .o_smooth_stop(o_smooth_stop),
  .o_servo_on(o_servo_on));
`default_nettype wire

// file: test/mio_master_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Fieldbus master model on the register bus
// ****************************************
module mio_master_model (
  input wire logic i_clk, // Clock
  input wire logic i_pready, // Ready
  input wire logic [31:0] i_prdata, // Read data
  input wire logic i_pslverr, // Error
  output logic o_psel, // Select
  output logic o_penable, // Enable
  output logic o_pwrite, // Direction
  output logic [7:0] o_paddr, // Address
  output logic [31:0] o_pwdata // Write data
);
  // Idle bus at time zero
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // One transfer, held until ready is sampled; released lines invert
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
  begin
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_pready !== 1'b1 && n < 20);
    if (i_pready !== 1'b1)
    begin
      tb.err_count++;
      tb.conclude();
    end
    else
    begin
      r = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
    end
  end
  endtask
  // Whole message: data bytes, then header, then commit
  task automatic msg(input logic [7:0] b0, input logic [4:0] c, input logic [31:0] d, input logic [2:0] ax);
    logic [31:0] r;
    logic e;
  begin
    xfer(1'b1, mio_pkg::A_CMD_HI, d, r, e);
    xfer(1'b1, mio_pkg::A_CMD_LO, {mio_pkg::AXIS_ID, mio_pkg::RSP_CUR_POS, ax, c, 8'h00, b0}, r, e);
    xfer(1'b1, mio_pkg::A_CTRL, 32'h1, r, e);
    repeat (2) @(posedge i_clk);
  end
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Testbench
// ****************************************
module tb;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, spulse, dir, hstop, sstop, servo;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] op;
  int err_count = 0;
  int checks = 0;
  int starts = 0;
  localparam logic [7:0] EN = 8'h80;
  localparam logic [7:0] VD = 8'h40;
  localparam logic [4:0] P = mio_pkg::CMD_TARGET_POS;
  localparam logic [4:0] C = mio_pkg::CMD_CONT_SPD;
  mio_decoder i_mio_decoder (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_traj_busy(busy), .o_start_pulse(spulse), .o_op(op), .o_direction(dir),
    .o_hard_stop(hstop), .o_smooth_stop(sstop), .o_servo_on(servo));
  mio_master_model i_mio_master_model (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata));
  // Clock, 40 ns period
  always #20 i_clk = ~i_clk;
  // Start events counted in the cycle they stand
  always @(posedge i_clk)
  begin
    if (spulse === 1'b1)
      starts++;
  end
  task automatic conclude();
  begin
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // Masked read compare; error flag must stay low on mapped places
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    logic e;
  begin
    i_mio_master_model.xfer(1'b0, a, 32'h0, v, e);
    chk({31'h0, e} | (v & m), exp);
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
  begin
    i_mio_master_model.xfer(1'b1, a, d, v, e);
  end
  endtask
  task automatic msg(input logic [7:0] b0, input logic [4:0] c, input logic [31:0] d);
  begin
    i_mio_master_model.msg(b0, c, d, mio_pkg::AXIS_ID);
  end
  endtask
  // Start edge, then start and valid dropped so nothing refreshes
  task automatic go(input logic [7:0] b0, input logic [4:0] c, input logic [31:0] d);
  begin
    msg(b0 | 8'h01, c, d);
    msg(b0 & 8'hBE, c, d);
  end
  endtask
  task automatic t_params();
    logic [4:0] codes [4] = '{mio_pkg::CMD_TARGET_SPD, mio_pkg::CMD_ACCEL, mio_pkg::CMD_DECEL, C};
    logic [7:0] regs [4] = '{mio_pkg::A_SPEED, mio_pkg::A_ACCEL, mio_pkg::A_DECEL, mio_pkg::A_CONT};
  begin
    chk({busy, op, servo, spulse}, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      msg(EN | VD, codes[i], 32'h100 + i);
      msg(EN, codes[i], 32'h200 + i);
      rdm(regs[i], '1, 32'h100 + i);
    end
    $display("params test done");
  end
  endtask
  task automatic t_pos();
    int s;
  begin
    wr(mio_pkg::A_CURPOS, 32'd200);
    wr(mio_pkg::A_INPOS_W, 32'd1000);
    go(EN | VD, P, 32'd300);
    rdm(mio_pkg::A_TARGET, '1, 32'd300);
    s = starts;
    msg(EN | VD | 8'h05, P, 32'd300);
    rdm(mio_pkg::A_TARGET, '1, 32'd500);
    chk(starts - s, 1);
    chk({busy, op}, 3'b100);
    msg(EN, P, 32'd0);
    chk({busy, 1'b0}, 2'b10);
    rdm(mio_pkg::A_RSP_LO, 32'hFF00_008C, 32'h2100_0084);
    rdm(mio_pkg::A_RSP_HI, '1, 32'd200);
    wr(mio_pkg::A_MONITOR, 32'h1 << mio_pkg::MON_DONE);
    wr(mio_pkg::A_MONITOR, 32'h0);
    chk(busy, 0);
    wr(mio_pkg::A_INPOS_W, 32'd10);
    rdm(mio_pkg::A_RSP_LO, 32'h5, 32'h0);
    s = starts;
    msg(VD | 8'h01, P, 32'd40);
    msg(EN, P, 32'd40);
    chk({busy, 31'(starts - s)}, 0);
    $display("positioning test done");
  end
  endtask
  task automatic t_cont();
    int s;
  begin
    wr(mio_pkg::A_ENDPOS, 32'h777);
    wr(mio_pkg::A_ACTDEF, 32'h0);
    s = starts;
    go(EN | VD | 8'h08, C, 32'd50);
    chk({busy, op, dir}, 4'b1011);
    go(EN | VD, mio_pkg::CMD_SWITCH_POS, 32'h0);
    chk(op, 2'd1);
    go(EN | VD, P, 32'd900);
    chk(op, 2'd0);
    rdm(mio_pkg::A_TARGET, '1, 32'd900);
    wr(mio_pkg::A_ACTDEF, 32'h8000);
    go(EN | VD, C, 32'd60);
    chk({op, dir}, 3'b010);
    go(EN | VD, mio_pkg::CMD_SWITCH_POS, 32'h0);
    chk(op, 2'd0);
    rdm(mio_pkg::A_TARGET, '1, 32'h777);
    chk(starts - s, 4);
    wr(mio_pkg::A_MONITOR, 32'h1);
    wr(mio_pkg::A_MONITOR, 32'h0);
    $display("continuous test done");
  end
  endtask
  // Origin return, stop levels, block run and monitored status bits
  task automatic t_status();
  begin
    go(EN | VD | 8'h30, mio_pkg::CMD_ORIGIN, 32'h5);
    chk({op, hstop, sstop}, 4'b1011);
    rdm(mio_pkg::A_EXEC, 32'hFF00, 32'h0500);
    msg(EN | VD | 8'h02, mio_pkg::CMD_NOP, 32'h0);
    rdm(mio_pkg::A_RSP_LO, 32'h2, 32'h2);
    wr(mio_pkg::A_MONITOR, 32'h2AB);
    rdm(mio_pkg::A_RSP_LO, 32'h001F_0033, 32'h0015_0020);
    wr(mio_pkg::A_MONITOR, 32'h0);
    $display("status test done");
  end
  endtask
  task automatic t_alarm();
    logic [31:0] v;
    logic e;
  begin
    wr(mio_pkg::A_CTRL, 32'h2);
    rdm(mio_pkg::A_RSP_LO, 32'h8, 32'h8);
    msg(EN | VD, mio_pkg::CMD_ALM_CLR, 32'h1);
    rdm(mio_pkg::A_RSP_LO, 32'h8, 32'h8);
    go(EN | VD, mio_pkg::CMD_ALM_CLR, 32'h1);
    rdm(mio_pkg::A_RSP_LO, 32'h8, 32'h0);
    i_mio_master_model.msg(EN | VD, mio_pkg::CMD_ACCEL, 32'h10, 3'h2);
    rdm(mio_pkg::A_RSP_LO, 32'h0080_0040, 32'h0080_0040);
    msg(EN, mio_pkg::CMD_ACCEL, 32'h10);
    rdm(mio_pkg::A_RSP_LO, 32'h0080_0000, 32'h0);
    i_mio_master_model.xfer(1'b0, 8'h80, 32'h0, v, e);
    chk({e, v[30:0]}, 32'h8000_0000);
    i_mio_master_model.xfer(1'b1, mio_pkg::A_TARGET, 32'h0, v, e);
    chk(e, 1'b1);
    rdm(mio_pkg::A_TARGET, '1, 32'h777);
    $display("alarm test done");
  end
  endtask
  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_params();
    t_pos();
    t_cont();
    t_status();
    t_alarm();
    conclude();
  end
endmodule
`default_nettype wire
